// File: core/adcc_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
// register byte offsets on the apb bus
`define ADCC_OFS_PINSEL    12'h000
`define ADCC_OFS_CTRL0     12'h004
`define ADCC_OFS_CTRL1     12'h008
`define ADCC_OFS_RESLO     12'h00C
`define ADCC_OFS_RESHI     12'h010
`define ADCC_OFS_INTCTL    12'h014
// first control register fields
`define ADCC_C0_START      7
`define ADCC_C0_PEND       6
`define ADCC_C0_POFF       5
`define ADCC_C0_CHLO       0
// second control register fields
`define ADCC_C1_CHHI       7
`define ADCC_C1_REFS       6
`define ADCC_C1_DIV        0
// interrupt control fields
`define ADCC_IC_GIE        0
`define ADCC_IC_CIE        1
`define ADCC_IC_FLAG       2
// reset values
`define ADCC_RST_PINSEL    8'hFF
`define ADCC_RST_POFF      1'b1
`define ADCC_RST_PEND      1'b1
// conversion length in conversion clock periods
`define ADCC_CONV_PERIODS  5'h10
`define ADCC_RES_BITS      12
`define ADCC_FULL_SCALE    12'hFFF
`endif

// File: core/adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_HELD, ST_CONV} adcc_state_t;
    // controls carried to the analog converter core
    typedef struct packed {
        logic       power_on;
        logic       ref_ext;
        logic [3:0] channel;
        logic       conv_reset;
        logic       conv_clk_en;
    } adcc_core_ctrl_t;
    // effective per-pin configuration
    typedef struct packed {
        logic [7:0] analog_en;
        logic [7:0] dir_input;
        logic [7:0] pullup_on;
        logic [7:0] digital_en;
    } adcc_pin_cfg_t;
endpackage

// File: core/adcc_clkdiv.sv
// conversion clock enable divider
`timescale 1ns/1ps
module adcc_clkdiv
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clear,
    input  wire logic [2:0] div_code,
    output logic            tick
);
    import adcc_pkg::*;

    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    wire  [5:0] limit;

    // terminal count for a code; undefined code 7 runs as divide by 64
    function automatic logic [5:0] div_limit(input logic [2:0] code);
        logic [6:0] span;
        span = (code == 3'h7) ? 7'h40 : (7'h01 << code);
        return 6'((span - 7'h01));
    endfunction

    // one-cycle enable every divided period
    assign limit    = div_limit(div_code);
    assign tick     = !clear && (cnt_reg >= limit);
    assign cnt_next = (clear || tick) ? 6'h00 : cnt_reg + 6'h01;

    // period counter
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_reg <= 6'h00;
        else
            cnt_reg <= cnt_next;
    end
endmodule

// File: core/adcc_ctrl.sv
// converter control block with apb register access
// Function
// - analog enable routes pin, disables others
// - analog pin drops its pull-high resistor
// - analog enable overrides port direction
// - reference from pin or supply by bit
// - conversion clock is system clock divided
// - power-off bit high switches converter off
// - four-bit channel split across both controls
// - interrupt needs global and converter enables
// - start high then low begins conversion
// - start held high forces flag, resets
// - flag clears at end, results valid
// - end of conversion sets request flag
// - conversion lasts sixteen conversion clock periods
// - reset leaves shared pins as analog inputs
// - result twelve bits, full scale all ones
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_ctrl
#(
    parameter int NPINS = 8
)
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic                         pslverr,
    output logic [31:0]                  prdata,
    input  wire logic [NPINS-1:0]        pin_direction_in,
    input  wire logic [NPINS-1:0]        pin_pullup_req,
    input  wire logic [11:0]             core_result,
    output adcc_pkg::adcc_pin_cfg_t      pin_cfg,
    output adcc_pkg::adcc_core_ctrl_t    core_ctrl,
    output logic                         adc_irq
);
    import adcc_pkg::*;

    // ************************************************************
    // parameter check
    // ************************************************************
    if (NPINS < 1 || NPINS > 8)
        $error("NPINS must lie between 1 and 8");

    // ************************************************************
    // registers and wires
    // ************************************************************
    logic [NPINS-1:0] analog_pin_enable_reg;
    logic             start_reg;
    logic             start_prev_reg;
    logic             pending_reg;
    logic             power_off_reg;
    logic [2:0]       chan_low_reg;
    logic             chan_high_reg;
    logic             ref_sel_reg;
    logic [2:0]       clk_div_reg;
    logic             gie_reg;
    logic             cie_reg;
    logic             irq_flag_reg;
    logic [11:0]      result_reg;
    logic [4:0]       period_cnt_reg;
    logic [31:0]      prdata_reg;
    adcc_state_t      state_reg;
    adcc_state_t      state_next;

    wire        setup_ph;
    wire        wr_acc;
    wire        hit_pinsel;
    wire        hit_ctrl0;
    wire        hit_ctrl1;
    wire        hit_reslo;
    wire        hit_reshi;
    wire        hit_intctl;
    wire        mapped;
    wire        start_fall;
    wire        conv_tick;
    wire        conv_done;
    wire        clr_flag;
    wire [31:0] rd_value;
    wire [7:0]  pin_ana;

    // ************************************************************
    // apb decode
    // ************************************************************
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] ofs);
        return a == ofs;
    endfunction

    assign setup_ph   = psel && !penable;
    assign wr_acc     = psel && penable && pwrite;
    assign hit_pinsel = hit(paddr, `ADCC_OFS_PINSEL);
    assign hit_ctrl0  = hit(paddr, `ADCC_OFS_CTRL0);
    assign hit_ctrl1  = hit(paddr, `ADCC_OFS_CTRL1);
    assign hit_reslo  = hit(paddr, `ADCC_OFS_RESLO);
    assign hit_reshi  = hit(paddr, `ADCC_OFS_RESHI);
    assign hit_intctl = hit(paddr, `ADCC_OFS_INTCTL);
    assign mapped     = hit_pinsel || hit_ctrl0 || hit_ctrl1
                     || hit_reslo || hit_reshi || hit_intctl;

    // access phase always completes in one cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_reg;

    // read mux; low byte holds result bits 7..0, high byte bits 11..8
    assign rd_value =
        hit_pinsel ? 32'(analog_pin_enable_reg) :
        hit_ctrl0  ? {24'h000000, start_reg, pending_reg, power_off_reg,
                      2'h0, chan_low_reg} :
        hit_ctrl1  ? {24'h000000, chan_high_reg, ref_sel_reg, 3'h0,
                      clk_div_reg} :
        hit_reslo  ? {24'h000000, result_reg[7:0]} :
        hit_reshi  ? {28'h0000000, result_reg[11:8]} :
        hit_intctl ? {29'h00000000, irq_flag_reg, cie_reg, gie_reg} :
        32'h00000000;

    // read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata_reg <= 32'h00000000;
        else if (setup_ph)
            prdata_reg <= pwrite ? 32'h00000000 : rd_value;
    end

    // ************************************************************
    // software control registers
    // ************************************************************
    // pin select resets to all-analog
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            analog_pin_enable_reg <= NPINS'(`ADCC_RST_PINSEL);
        else if (wr_acc && hit_pinsel)
            analog_pin_enable_reg <= pwdata[NPINS-1:0];
    end

    // first control register; pending flag is hardware owned
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            start_reg     <= 1'b0;
            power_off_reg <= `ADCC_RST_POFF;
            chan_low_reg  <= 3'h0;
        end
        else if (wr_acc && hit_ctrl0)
        begin
            start_reg     <= pwdata[`ADCC_C0_START];
            power_off_reg <= pwdata[`ADCC_C0_POFF];
            chan_low_reg  <= pwdata[`ADCC_C0_CHLO +: 3];
        end
    end

    // second control register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            chan_high_reg <= 1'b0;
            ref_sel_reg   <= 1'b0;
            clk_div_reg   <= 3'h0;
        end
        else if (wr_acc && hit_ctrl1)
        begin
            chan_high_reg <= pwdata[`ADCC_C1_CHHI];
            ref_sel_reg   <= pwdata[`ADCC_C1_REFS];
            clk_div_reg   <= pwdata[`ADCC_C1_DIV +: 3];
        end
    end

    // interrupt enables; writing 0 to the flag clears it, set wins
    assign clr_flag = wr_acc && hit_intctl && !pwdata[`ADCC_IC_FLAG];
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gie_reg      <= 1'b0;
            cie_reg      <= 1'b0;
            irq_flag_reg <= 1'b0;
        end
        else
        begin
            if (wr_acc && hit_intctl)
            begin
                gie_reg <= pwdata[`ADCC_IC_GIE];
                cie_reg <= pwdata[`ADCC_IC_CIE];
            end
            if (conv_done)
                irq_flag_reg <= 1'b1;
            else if (clr_flag)
                irq_flag_reg <= 1'b0;
        end
    end

    // both enables gate the request onto the processor line
    assign adc_irq = gie_reg && cie_reg && irq_flag_reg;

    // ************************************************************
    // conversion clock
    // ************************************************************
    // divider restarts at each conversion so periods are whole
    adcc_clkdiv u_div
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .clear    (state_reg != ST_CONV),
        .div_code (clk_div_reg),
        .tick     (conv_tick)
    );

    // ************************************************************
    // start sequence and conversion
    // ************************************************************
    assign start_fall = start_prev_reg && !start_reg;
    assign conv_done  = (state_reg == ST_CONV) && conv_tick
                     && (period_cnt_reg == `ADCC_CONV_PERIODS - 5'h01);

    // state selection; power off aborts everything
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (start_reg) state_next = ST_HELD;
            ST_HELD: if (start_fall) state_next = ST_CONV;
            ST_CONV:
            begin
                if (start_reg)
                    state_next = ST_HELD;
                else if (conv_done)
                    state_next = ST_IDLE;
            end
        endcase
        if (power_off_reg)
            state_next = ST_IDLE;
    end

    // state, start history and period count
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg      <= ST_IDLE;
            start_prev_reg <= 1'b0;
            period_cnt_reg <= 5'h00;
        end
        else
        begin
            state_reg      <= state_next;
            start_prev_reg <= start_reg;
            if (state_reg != ST_CONV)
                period_cnt_reg <= 5'h00;
            else if (conv_tick)
                period_cnt_reg <= period_cnt_reg + 5'h01;
        end
    end

    // pending flag forced while start held, cleared at the end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            pending_reg <= `ADCC_RST_PEND;
        else if (start_reg)
            pending_reg <= 1'b1;
        else if (conv_done)
            pending_reg <= 1'b0;
    end

    // result captured at the end of each conversion
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            result_reg <= 12'h000;
        else if (conv_done)
            result_reg <= core_result;
    end

    // ************************************************************
    // outputs to the converter core and the pins
    // ************************************************************
    assign core_ctrl.power_on    = !power_off_reg;
    assign core_ctrl.ref_ext     = ref_sel_reg;
    assign core_ctrl.channel     = {chan_high_reg, chan_low_reg};
    assign core_ctrl.conv_reset  = start_reg || power_off_reg;
    assign core_ctrl.conv_clk_en = conv_tick;

    // analog selection overrides direction, pull-high and functions
    assign pin_ana              = 8'(analog_pin_enable_reg);
    assign pin_cfg.analog_en    = pin_ana;
    assign pin_cfg.digital_en   = ~pin_ana;
    assign pin_cfg.dir_input    = pin_ana | 8'(pin_direction_in);
    assign pin_cfg.pullup_on    = ~pin_ana & 8'(pin_pullup_req);

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    chk_start_held_flag: assert property (
        start_reg |-> core_ctrl.conv_reset ##1 pending_reg)
        else $error("start held but flag or core reset low");

    chk_fall_starts_conv: assert property (
        state_reg == ST_HELD && start_fall && !power_off_reg
        |=> state_reg == ST_CONV)
        else $error("start release did not begin conversion");

    chk_done_clears_flag: assert property (
        conv_done && !start_reg
        |=> !pending_reg && result_reg == $past(core_result))
        else $error("end of conversion left flag or result wrong");

    chk_done_sets_req: assert property (
        conv_done |=> irq_flag_reg ##1 (irq_flag_reg || $past(clr_flag)))
        else $error("request flag not set at end of conversion");

    chk_irq_gating: assert property (
        adc_irq |-> gie_reg && cie_reg && irq_flag_reg)
        else $error("interrupt raised without both enables");

    chk_conv_sixteen: assert property (
        conv_done |-> period_cnt_reg == 5'h0F
        && $past(state_reg, 15) == ST_CONV)
        else $error("conversion ended after wrong period count");

    chk_power_off_idle: assert property (
        power_off_reg |-> !core_ctrl.power_on ##1 state_reg == ST_IDLE)
        else $error("converter active while powered off");

    chk_pin_override: assert property (
        (pin_ana & ~pin_cfg.dir_input) == 8'h00
        && (pin_ana & (pin_cfg.pullup_on | pin_cfg.digital_en)) == 8'h00)
        else $error("analog pin kept digital settings");

    chk_channel_join: assert property (
        wr_acc && hit_ctrl1 |=> core_ctrl.channel[3] == $past(pwdata[7]))
        else $error("channel high bit not taken");

    chk_ref_select: assert property (
        wr_acc && hit_ctrl1 |=> core_ctrl.ref_ext == $past(pwdata[6]))
        else $error("reference select not applied");
endmodule

// File: test/adcc_core_model.sv
// behavioural model of the analog converter core behind the control block
`timescale 1ns/1ps
module adcc_core_model
    import adcc_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire adcc_pkg::adcc_core_ctrl_t core_ctrl,
    output logic [11:0]                    core_result
);
    logic [11:0] code_reg;
    logic [11:0] sample;

    // channel 0 sits at the reference level, so it reads full scale
    assign sample = (core_ctrl.channel == 4'h0) ? 12'hFFF :
        {core_ctrl.ref_ext, 3'h5, core_ctrl.channel, ~core_ctrl.channel};

    // a core held in reset or unpowered shows a moving pattern
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            code_reg <= 12'h000;
        else if (core_ctrl.conv_reset || !core_ctrl.power_on)
            code_reg <= ~code_reg;
        else if (core_ctrl.conv_clk_en)
            code_reg <= sample;
    end

    assign core_result = code_reg;
endmodule

// File: test/adcc_ctrl_tb.sv
// self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_ctrl_tb;
    import adcc_pkg::*;
    logic            clk, rst_b, psel, penable, pwrite;
    logic            pready, pslverr, adc_irq;
    logic [11:0]     paddr, core_result;
    logic [31:0]     pwdata, prdata;
    logic [7:0]      pin_direction_in, pin_pullup_req;
    adcc_pin_cfg_t   pin_cfg;
    adcc_core_ctrl_t core_ctrl;
    int              err_total = 0;
    int              comparisons = 0;
    int              cycles = 0;

    adcc_ctrl #(.NPINS(8)) dut (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .pin_direction_in(pin_direction_in),
        .pin_pullup_req(pin_pullup_req), .core_result(core_result),
        .pin_cfg(pin_cfg), .core_ctrl(core_ctrl), .adc_irq(adc_irq));

    adcc_core_model core (.clk(clk), .rst_b(rst_b),
        .core_ctrl(core_ctrl), .core_result(core_result));

    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t run timed out", $time);
            results;
        end
    end

    task automatic results;
        $display("counts: %0d comparisons, %0d mismatches",
                 comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    // one apb transfer: setup, access held until pready at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    task automatic t_reset;
        logic [31:0] q;
        rd(`ADCC_OFS_PINSEL, q);
        chk(q, 32'h0000_00FF, "pin select reset");
        rd(`ADCC_OFS_CTRL0, q);
        chk(q, 32'h0000_0060, "first control reset");
        chk(pin_cfg.analog_en, 8'hFF, "pins analog at reset");
        chk(pin_cfg.pullup_on, 8'h00, "pull-high dropped");
        chk(core_ctrl.power_on, 1'b0, "core off at reset");
        $display("test reset done");
    endtask

    task automatic t_pins;
        logic [31:0] q;
        wr(`ADCC_OFS_PINSEL, 32'h0000_000F);
        rd(`ADCC_OFS_PINSEL, q);
        chk(q, 32'h0000_000F, "pin select readback");
        chk(pin_cfg.analog_en, 8'h0F, "analog pins");
        chk(pin_cfg.digital_en, 8'hF0, "shared functions off");
        chk(pin_cfg.pullup_on, 8'hF0, "pull-high on digital");
        chk(pin_cfg.dir_input, 8'h0F, "direction override");
        $display("test pins done");
    endtask

    task automatic t_bad;
        logic [31:0] q;
        logic        e;
        apb(1'b0, 12'h03C, 32'h0, q, e);
        chk(e, 1'b1, "unmapped error");
        chk(q, 32'h0, "unmapped data");
        $display("test unmapped done");
    endtask

    // one conversion for divide code c, counting conversion clock ticks
    task automatic t_conv(input int c);
        int          d, n, t, last, extra;
        logic [3:0]  ch;
        logic [11:0] exp;
        logic [31:0] q;
        d = (c == 7) ? 64 : (1 << c);
        ch = {c[0], c[2:0]};
        exp = (ch == 4'h0) ? 12'hFFF : {c[1], 3'h5, ch, ~ch};
        wr(`ADCC_OFS_CTRL1, {24'h0, ch[3], c[1], 3'h0, c[2:0]});
        wr(`ADCC_OFS_CTRL0, {24'h0, 5'h00, ch[2:0]});
        wr(`ADCC_OFS_CTRL0, {24'h0, 5'h10, ch[2:0]});
        rd(`ADCC_OFS_CTRL0, q);
        chk(q[6], 1'b1, "pending while held");
        chk(core_ctrl.conv_reset, 1'b1, "core held in reset");
        chk(core_ctrl.channel, ch, "channel");
        chk(core_ctrl.ref_ext, c[1], "reference");
        chk(core_ctrl.power_on, 1'b1, "core powered");
        wr(`ADCC_OFS_INTCTL, 32'h0);
        wr(`ADCC_OFS_CTRL0, {24'h0, 5'h00, ch[2:0]});
        n = 0;
        last = 0;
        extra = 0;
        for (t = 0; t < 16 * d + 40 && n < 16; t++)
        begin
            @(posedge clk);
            if (core_ctrl.conv_clk_en === 1'b1)
            begin
                if (n > 0)
                    chk(32'(t - last), 32'(d), "tick spacing");
                last = t;
                n++;
            end
        end
        chk(32'(n), 32'd16, "tick count");
        for (t = 0; t < 2 * d + 8; t++)
        begin
            @(posedge clk);
            if (core_ctrl.conv_clk_en === 1'b1)
                extra++;
        end
        chk(32'(extra), 32'd0, "ticks after done");
        rd(`ADCC_OFS_CTRL0, q);
        chk(q[6], 1'b0, "pending cleared");
        rd(`ADCC_OFS_RESLO, q);
        chk(q, {24'h0, exp[7:0]}, "result low");
        rd(`ADCC_OFS_RESHI, q);
        chk(q, {28'h0, exp[11:8]}, "result high");
        rd(`ADCC_OFS_INTCTL, q);
        chk(q[2], 1'b1, "request flag");
        $display("test conversion code %0d done", c);
    endtask

    // enables walked with the request flag standing
    task automatic t_irq;
        logic [31:0] q;
        logic [1:0]  i;
        for (int k = 0; k < 4; k++)
        begin
            i = 2'(k);
            wr(`ADCC_OFS_INTCTL, {29'h0, 1'b1, i[1], i[0]});
            @(posedge clk);
            chk(adc_irq, (k == 3), "irq gating");
        end
        wr(`ADCC_OFS_INTCTL, 32'h0000_0003);
        rd(`ADCC_OFS_INTCTL, q);
        chk(q, 32'h0000_0003, "flag cleared");
        chk(adc_irq, 1'b0, "irq off after clear");
        $display("test interrupt done");
    endtask

    // restart and power off while converting; neither may complete
    task automatic t_abort;
        logic [31:0] q;
        wr(`ADCC_OFS_CTRL1, 32'h0000_0006);
        wr(`ADCC_OFS_CTRL0, 32'h0000_0000);
        wr(`ADCC_OFS_CTRL0, 32'h0000_0080);
        wr(`ADCC_OFS_CTRL0, 32'h0000_0000);
        repeat (100) @(posedge clk);
        wr(`ADCC_OFS_CTRL0, 32'h0000_0080);
        rd(`ADCC_OFS_CTRL0, q);
        chk(q, 32'h0000_00C0, "restart holds pending");
        chk(core_ctrl.conv_reset, 1'b1, "restart resets core");
        wr(`ADCC_OFS_CTRL0, 32'h0000_0000);
        repeat (100) @(posedge clk);
        wr(`ADCC_OFS_CTRL0, 32'h0000_0020);
        repeat (2000) @(posedge clk);
        chk(core_ctrl.conv_clk_en, 1'b0, "no ticks when off");
        chk(core_ctrl.power_on, 1'b0, "core off");
        rd(`ADCC_OFS_CTRL0, q);
        chk(q, 32'h0000_0060, "power off abort");
        rd(`ADCC_OFS_INTCTL, q);
        chk(q[2], 1'b0, "no request after abort");
        chk(adc_irq, 1'b0, "no irq after abort");
        $display("test abort done");
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pin_direction_in = 8'h00;
        pin_pullup_req = 8'hFF;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_pins;
        t_bad;
        for (int c = 0; c < 8; c++)
            t_conv(c);
        t_irq;
        t_abort;
        results;
    end
endmodule
